/* design/ltc_pkg.sv */
// constants and state layout for the display timing and drive control block
package ltc_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_POWER = 8'h04;
	localparam logic [7:0] OFS_CONTRAST = 8'h08;
	localparam logic [7:0] OFS_RATIO = 8'h0C;
	localparam logic [7:0] OFS_LINE_REV = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	// control register bit positions
	localparam int CTRL_MASTER = 0;
	localparam int CTRL_OSC_SEL = 1;
	localparam int CTRL_OSC_ON = 2;
	localparam int CTRL_ROW_REV = 3;
	localparam int CTRL_DISP_ON = 4;
	localparam int CTRL_LREV_EN = 5;
	localparam int CTRL_START_LSB = 8;
	localparam int CTRL_W = 6;
	localparam int START_W = 6;
	localparam int PWR_PUMP = 2;
	localparam int PWR_REG = 1;
	localparam int PWR_FOLLOW = 0;
	localparam int PWR_W = 3;
	localparam int CONTRAST_W = 6;
	localparam int RATIO_W = 3;
	localparam int LREV_W = 6;
	localparam logic [5:0] CONTRAST_MAX = 6'h3F;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	localparam logic [2:0] PWR_RESET = 3'h0;
	localparam logic [5:0] CONTRAST_RESET = 6'h00;
	localparam logic [2:0] RATIO_RESET = 3'h0;
	localparam logic [5:0] LREV_RESET = 6'h00;
	// scan geometry
	localparam int LINES = 65;
	localparam int ROWS = 65;
	localparam int COLS = 224;
	localparam int LINE_W = 7;
	localparam logic [6:0] LAST_LINE = 7'h40;
	localparam logic [6:0] HALF_LINES = 7'h21;
	localparam logic [6:0] TOP_ROW = 7'h3F;
	// internal oscillator line period
	localparam int CLK_HZ = 40_000_000;
	localparam int LINE_PERIOD_NS = 10_000;
	localparam int LINE_CYC = (LINE_PERIOD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int DIV_W = 16;
	localparam logic [15:0] DIV_LAST = 16'(LINE_CYC - 1);
	localparam logic [15:0] DIV_HALF = 16'(LINE_CYC / 2);
	localparam int PIN_N = 4;
	localparam int PIN_POL = 0;
	localparam int PIN_SYNC = 1;
	localparam int PIN_TICK = 2;
	localparam int PIN_BLANK = 3;

	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [START_W-1:0] start_line;
		logic [PWR_W-1:0] power;
		logic [CONTRAST_W-1:0] contrast;
		logic [RATIO_W-1:0] ratio;
		logic [LREV_W-1:0] lrev;
		logic [DIV_W-1:0] div;
		logic [LINE_W-1:0] line;
		logic [LREV_W-1:0] lrev_pos;
		logic lrev_act;
		logic pol;
		logic tick_prev;
		logic sync_prev;
		logic [LINE_W-1:0] scan_addr;
		logic [2*COLS-1:0] column_driver_outputs;
		logic [2*ROWS-1:0] row_driver_outputs;
		logic [DATA_W-1:0] rdata;
	} ltc_state_t;
endpackage

/* design/ltc_sync2.sv */
// two-flop synchroniser for the shared timing pins
`timescale 1ns/1ps
`default_nettype none
module ltc_sync2 #(
	parameter int W = 1
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end
	assign sync_o = sync_q;
endmodule
`default_nettype wire

/* design/ltc_timing.sv */
// display timing generator, row scan, polarity, pin direction and power/contrast control
// How it works
// - line ticks latch row data to columns
// - scan read port separate from host
// - row timing, polarity, sync from clock
// - polarity toggles every frame by default
// - line mode: invert every m+1 lines
// - master sync high half frame
// - slave realigns line counter on sync
// - master sources three timing signals, the line tick as a fourth only with oscillator select
// - pin directions follow master, oscillator select
// - row order normal up, reversed down
// - each output picks one of four levels
// - drive voltage enables only as master
// - three power enable bits pump/regulator/follower
// - six-bit contrast register, 64 steps
// - coefficient equals 63 minus contrast
// - three-bit ratio register, own write
// - oscillator runs only master with select
// - 65 lines per frame from start
`timescale 1ns/1ps
`default_nettype none
module ltc_timing (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic [6:0] scan_addr_o,
	input wire logic [223:0] scan_data_i,
	output logic [447:0] column_driver_outputs_o,
	output logic [129:0] row_driver_outputs_o,
	input wire logic ac_polarity_i,
	output logic ac_polarity_o,
	output logic ac_polarity_oe_o,
	input wire logic sync_i,
	output logic sync_o,
	output logic sync_oe_o,
	input wire logic line_tick_pin_i,
	output logic line_tick_pin_o,
	output logic line_tick_pin_oe_o,
	input wire logic display_blank_line_i,
	output logic display_blank_line_o,
	output logic display_blank_line_oe_o,
	output logic osc_run_o,
	output logic pump_en_o,
	output logic regulator_en_o,
	output logic follower_en_o,
	output logic [5:0] contrast_coef_o,
	output logic [2:0] ratio_o
);
	ltc_pkg::ltc_state_t s_q;
	ltc_pkg::ltc_state_t s_d;
	logic [ltc_pkg::PIN_N-1:0] pins_raw;
	logic [ltc_pkg::PIN_N-1:0] pins_s;
	logic master;
	logic osc_mode;
	logic tick;
	logic frame_end;
	logic sync_rise;
	logic blank;
	logic pol_now;
	logic [6:0] row;
	logic [6:0] next_line;
	logic [6:0] addr_sum;

	assign pins_raw = {display_blank_line_i, line_tick_pin_i, sync_i, ac_polarity_i};

	// pin levels from outside the clock domain
	ltc_sync2 #(
		.W(ltc_pkg::PIN_N)
	) u_pin_sync (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.async_i(pins_raw),
		.sync_o(pins_s)
	);

	assign master = s_q.ctrl[ltc_pkg::CTRL_MASTER];
	// internal oscillator only as master with source selected
	assign osc_mode = master & s_q.ctrl[ltc_pkg::CTRL_OSC_SEL];
	assign sync_rise = pins_s[ltc_pkg::PIN_SYNC] & ~s_q.sync_prev;
	assign frame_end = tick & (s_q.line == ltc_pkg::LAST_LINE);
	// slave follows master's blank line, master drives its own
	assign blank = master ? ~s_q.ctrl[ltc_pkg::CTRL_DISP_ON] :
		pins_s[ltc_pkg::PIN_BLANK];
	assign pol_now = master ? s_q.pol : pins_s[ltc_pkg::PIN_POL];
	// row 64 is the indicator row and is never mirrored
	assign row = (s_q.ctrl[ltc_pkg::CTRL_ROW_REV] && s_q.line != ltc_pkg::LAST_LINE) ?
		(ltc_pkg::TOP_ROW - s_q.line) : s_q.line;
	assign next_line = (s_q.line == ltc_pkg::LAST_LINE) ? 7'h00 : (s_q.line + 7'h01);
	assign addr_sum = 7'(s_q.start_line) + next_line;

	always_comb
	begin
		s_d = s_q;
		tick = 1'b0;
		s_d.tick_prev = pins_s[ltc_pkg::PIN_TICK];
		s_d.sync_prev = pins_s[ltc_pkg::PIN_SYNC];
		// line tick: own divider or edge on the line tick pin
		if (osc_mode)
		begin
			if (s_q.ctrl[ltc_pkg::CTRL_OSC_ON])
			begin
				if (s_q.div == ltc_pkg::DIV_LAST)
				begin
					s_d.div = '0;
					tick = 1'b1;
				end
				else
				begin
					s_d.div = s_q.div + 16'h0001;
				end
			end
		end
		else
		begin
			s_d.div = '0;
			tick = pins_s[ltc_pkg::PIN_TICK] & ~s_q.tick_prev;
		end

		if (tick)
		begin
			// latch the row fetched during the last line period
			for (int c = 0; c < ltc_pkg::COLS; c++)
			begin
				s_d.column_driver_outputs[2*c +: 2] = {pol_now, scan_data_i[c] & ~blank};
			end
			for (int r = 0; r < ltc_pkg::ROWS; r++)
			begin
				s_d.row_driver_outputs[2*r +: 2] = {pol_now, (7'(r) == row) & ~blank};
			end
			s_d.line = next_line;
			// wrap the start-relative address inside the 65-line area
			s_d.scan_addr = (addr_sum > ltc_pkg::LAST_LINE) ?
				(addr_sum - 7'(ltc_pkg::LINES)) : addr_sum;
			if (s_q.lrev_act)
			begin
				if (s_q.lrev_pos == s_q.lrev)
				begin
					s_d.lrev_pos = '0;
					s_d.pol = ~s_q.pol;
				end
				else
				begin
					s_d.lrev_pos = s_q.lrev_pos + 6'h01;
				end
			end
			else if (frame_end)
			begin
				s_d.pol = ~s_q.pol;
			end
			if (frame_end)
			begin
				// mode changes take hold only between frames
				s_d.lrev_act = s_q.ctrl[ltc_pkg::CTRL_LREV_EN];
				s_d.lrev_pos = '0;
			end
		end

		// slave: master's sync rise marks frame start
		if (!master && sync_rise)
		begin
			s_d.line = '0;
			s_d.scan_addr = 7'(s_q.start_line);
			s_d.lrev_pos = '0;
		end

		// register writes hold until rewritten
		if (wr_i)
		begin
			unique case (addr_i)
				ltc_pkg::OFS_CTRL:
				begin
					s_d.ctrl = wdata_i[ltc_pkg::CTRL_W-1:0];
					s_d.start_line = wdata_i[ltc_pkg::CTRL_START_LSB +: ltc_pkg::START_W];
				end
				ltc_pkg::OFS_POWER: s_d.power = wdata_i[ltc_pkg::PWR_W-1:0];
				ltc_pkg::OFS_CONTRAST: s_d.contrast = wdata_i[ltc_pkg::CONTRAST_W-1:0];
				ltc_pkg::OFS_RATIO: s_d.ratio = wdata_i[ltc_pkg::RATIO_W-1:0];
				ltc_pkg::OFS_LINE_REV: s_d.lrev = wdata_i[ltc_pkg::LREV_W-1:0];
				default:
				begin
				end
			endcase
		end

		s_d.rdata = '0;
		if (rd_i)
		begin
			unique case (addr_i)
				ltc_pkg::OFS_CTRL:
				begin
					s_d.rdata[ltc_pkg::CTRL_W-1:0] = s_q.ctrl;
					s_d.rdata[ltc_pkg::CTRL_START_LSB +: ltc_pkg::START_W] = s_q.start_line;
				end
				ltc_pkg::OFS_POWER: s_d.rdata[ltc_pkg::PWR_W-1:0] = s_q.power;
				ltc_pkg::OFS_CONTRAST: s_d.rdata[ltc_pkg::CONTRAST_W-1:0] = s_q.contrast;
				ltc_pkg::OFS_RATIO: s_d.rdata[ltc_pkg::RATIO_W-1:0] = s_q.ratio;
				ltc_pkg::OFS_LINE_REV: s_d.rdata[ltc_pkg::LREV_W-1:0] = s_q.lrev;
				ltc_pkg::OFS_STATUS:
				begin
					s_d.rdata[6:0] = s_q.line;
					s_d.rdata[8] = pol_now;
					s_d.rdata[9] = s_q.lrev_act;
					s_d.rdata[10] = blank;
					s_d.rdata[22:16] = s_q.scan_addr;
				end
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign rdata_o = s_q.rdata;
	assign scan_addr_o = s_q.scan_addr;
	assign column_driver_outputs_o = s_q.column_driver_outputs;
	assign row_driver_outputs_o = s_q.row_driver_outputs;

	// pin directions and master-side levels
	assign ac_polarity_oe_o = master;
	assign sync_oe_o = master;
	assign display_blank_line_oe_o = master;
	assign line_tick_pin_oe_o = osc_mode;
	assign ac_polarity_o = master & s_q.pol;
	// sync high for first 33 of 65 lines, near half duty
	assign sync_o = master & (s_q.line < ltc_pkg::HALF_LINES);
	assign line_tick_pin_o = osc_mode & (s_q.div < ltc_pkg::DIV_HALF);
	assign display_blank_line_o = master & ~s_q.ctrl[ltc_pkg::CTRL_DISP_ON];
	assign osc_run_o = osc_mode & s_q.ctrl[ltc_pkg::CTRL_OSC_ON];

	// supply generation is inert on a slave
	assign pump_en_o = master & s_q.power[ltc_pkg::PWR_PUMP];
	assign regulator_en_o = master & s_q.power[ltc_pkg::PWR_REG];
	assign follower_en_o = master & s_q.power[ltc_pkg::PWR_FOLLOW];
	assign contrast_coef_o = ltc_pkg::CONTRAST_MAX - s_q.contrast;
	assign ratio_o = s_q.ratio;
endmodule
`default_nettype wire

/* sim/ltc_peer_model.sv */
// timing source standing in for the chip at the far end of the shared pins
`timescale 1ns/1ps
`default_nettype none
module ltc_peer_model #(
	parameter int PER = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	output logic pol_o,
	output logic sync_o,
	output logic tick_o,
	output logic blank_o
);
	int c;
	int ln;
	// short line period keeps a frame near 520 clocks
	always_ff @(posedge clk_i or posedge rst_i)
		if (rst_i)
		begin
			c <= 0;
			ln <= 0;
			pol_o <= 1'b0;
		end
		else if (c == PER - 1)
		begin
			c <= 0;
			ln <= (ln == 64) ? 0 : ln + 1;
			if (ln == 64)
				pol_o <= ~pol_o;
		end
		else
			c <= c + 1;
	assign tick_o = c < 2;
	assign sync_o = ln < 33;
	assign blank_o = 1'b0;
endmodule
`default_nettype wire

/* sim/ltc_timing_props.sv */
// port assertions for the display timing block
`timescale 1ns/1ps
`default_nettype none
module ltc_timing_chk (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic [6:0] scan_addr_o,
	input wire logic [129:0] row_driver_outputs_o,
	input wire logic ac_polarity_oe_o,
	input wire logic sync_oe_o,
	input wire logic line_tick_pin_oe_o,
	input wire logic display_blank_line_oe_o,
	input wire logic osc_run_o,
	input wire logic pump_en_o,
	input wire logic regulator_en_o,
	input wire logic follower_en_o,
	input wire logic [5:0] contrast_coef_o,
	input wire logic [2:0] ratio_o
);
	logic [64:0] sel;
	always_comb
		for (int r = 0; r < 65; r++)
			sel[r] = row_driver_outputs_o[2*r];
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	coef_track_a: assert property (
		wr_i && addr_i == 8'h08 |=> ##1 contrast_coef_o == 6'h3F - $past(wdata_i[5:0], 2))
		else $error("contrast coefficient wrong");
	ratio_track_a: assert property (
		wr_i && addr_i == 8'h0C |=> ##1 ratio_o == $past(wdata_i[2:0], 2))
		else $error("ratio code wrong");
	pin_group_a: assert property (
		sync_oe_o == ac_polarity_oe_o && display_blank_line_oe_o == ac_polarity_oe_o)
		else $error("timing pin directions differ");
	tick_dir_a: assert property (line_tick_pin_oe_o |-> ac_polarity_oe_o)
		else $error("line tick driven as slave");
	osc_gate_a: assert property (
		osc_run_o |-> line_tick_pin_oe_o && ac_polarity_oe_o)
		else $error("oscillator runs outside master");
	slave_power_a: assert property (
		!ac_polarity_oe_o |-> !(pump_en_o || regulator_en_o || follower_en_o))
		else $error("power enabled as slave");
	power_hold_a: assert property (
		$changed({pump_en_o, regulator_en_o, follower_en_o}) |-> $past(wr_i) || $past(wr_i, 2))
		else $error("power bits changed without write");
	scan_range_a: assert property (scan_addr_o <= 7'h40)
		else $error("scan address out of range");
	row_one_a: assert property ($onehot0(sel))
		else $error("more than one row selected");
endmodule
bind ltc_timing ltc_timing_chk u_chk (.ref_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i,
	.scan_addr_o, .row_driver_outputs_o, .ac_polarity_oe_o, .sync_oe_o,
	.line_tick_pin_oe_o, .display_blank_line_oe_o, .osc_run_o, .pump_en_o,
	.regulator_en_o, .follower_en_o, .contrast_coef_o, .ratio_o);
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the display timing block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o;
	logic pol, pol_oe, syn, syn_oe, tck, tck_oe, blk, blk_oe, osc;
	logic m_pol, m_syn, m_tck, m_blk, tck_q, pump, regu, fol;
	logic [5:0] coef;
	logic [2:0] ratio;
	logic [129:0] row_driver_outputs;
	logic [447:0] column_driver_outputs;
	logic [6:0] scan_addr;
	int hi;
	int num_errors = 0;
	int checks = 0;
	int n;
	always #12.5 ref_clk_i = ~ref_clk_i;
	always_ff @(posedge ref_clk_i) tck_q <= m_tck;
	ltc_peer_model #(.PER(8)) peer (.clk_i(ref_clk_i), .rst_i(rst_i), .pol_o(m_pol),
		.sync_o(m_syn), .tick_o(m_tck), .blank_o(m_blk));
	ltc_timing uut (.ref_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.scan_addr_o(scan_addr), .scan_data_i({7{32'hA5C30F96}}), .column_driver_outputs_o(column_driver_outputs),
		.row_driver_outputs_o(row_driver_outputs), .ac_polarity_i(pol_oe ? pol : m_pol), .ac_polarity_o(pol),
		.ac_polarity_oe_o(pol_oe), .sync_i(syn_oe ? syn : m_syn), .sync_o(syn),
		.sync_oe_o(syn_oe), .line_tick_pin_i(tck_oe ? tck : m_tck), .line_tick_pin_o(tck),
		.line_tick_pin_oe_o(tck_oe), .display_blank_line_i(blk_oe ? blk : m_blk),
		.display_blank_line_o(blk), .display_blank_line_oe_o(blk_oe), .osc_run_o(osc),
		.pump_en_o(pump), .regulator_en_o(regu), .follower_en_o(fol),
		.contrast_coef_o(coef), .ratio_o(ratio));
	task automatic conclude;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
		@(posedge ref_clk_i);
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		@(negedge ref_clk_i);
		chk(nm, e, rdata_o);
		@(posedge ref_clk_i);
	endtask
	// ticks between two polarity flips; the pin synchroniser delay cancels
	task automatic span(output int k);
		logic p;
		int i;
		k = 0;
		hi = 0;
		for (int j = 0; j < 2; j++)
		begin
			p = pol;
			for (i = 0; i < 3000 && pol === p; i++)
			begin
				@(negedge ref_clk_i);
				if (j == 1 && m_tck && !tck_q)
				begin
					k++;
					if (syn)
						hi++;
				end
			end
			if (i == 3000)
			begin
				num_errors++;
				conclude();
			end
		end
	endtask
	// clocks between two rises of the own line tick pin
	task automatic period(output int k);
		logic t;
		int e;
		k = 0;
		e = 0;
		t = tck;
		for (int i = 0; i < 1200 && e < 2; i++)
		begin
			@(negedge ref_clk_i);
			if (tck && !t)
				e++;
			if (e == 1)
				k++;
			t = tck;
		end
	endtask
	// slave: line count follows the master's sync; rows show the line just ended
	task automatic scan_chk(input logic rev, input int st);
		int ln;
		int pv;
		int ex;
		int idx;
		int cnt;
		logic z;
		logic go;
		cnt = 0;
		z = 1'b0;
		go = 1'b0;
		for (int i = 0; i < 1400 && cnt < 66; i++)
		begin
			@(negedge ref_clk_i);
			if (peer.ln == 0 && peer.c == 0)
				z = 1'b1;
			if (z && peer.ln == 1)
				go = 1'b1;
			if (go && peer.c == 5)
			begin
				ln = peer.ln;
				pv = (ln == 0) ? 64 : ln - 1;
				ex = (rev && pv != 64) ? 63 - pv : pv;
				idx = 127;
				for (int r = 0; r < 65; r++)
					if (row_driver_outputs[2*r])
						idx = r;
				chk("row", 32'(ex), 32'(idx));
				chk("scan", 32'((st + ln) % 65), 32'(scan_addr));
				chk("seg", {28'h0, m_pol, 1'b1, m_pol, 1'b0}, 32'(column_driver_outputs[3:0]));
				cnt++;
			end
		end
		chk("lines", 32'd66, 32'(cnt));
	endtask
	initial
	begin
		repeat (6) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		@(posedge ref_clk_i);
		chk("coef", 32'h3F, 32'(coef));
		chk("oe", 32'h0, 32'({pol_oe, syn_oe, tck_oe, blk_oe}));
		rchk("ctrl", 8'h00, 32'h0);
		wr(8'h08, 32'h3F);
		chk("coef", 32'h0, 32'(coef));
		rchk("contrast", 8'h08, 32'h3F);
		wr(8'h08, 32'h15);
		chk("coef", 32'h2A, 32'(coef));
		wr(8'h0C, 32'h5);
		chk("ratio", 32'h5, 32'(ratio));
		wr(8'h04, 32'h7);
		chk("power", 32'h0, 32'({pump, regu, fol}));
		wr(8'h00, 32'h7);
		chk("oe", 32'hF, 32'({pol_oe, syn_oe, tck_oe, blk_oe}));
		chk("osc", 32'h1, 32'(osc));
		chk("power", 32'h7, 32'({pump, regu, fol}));
		period(n);
		chk("tick period", 32'(ltc_pkg::LINE_CYC), 32'(n));
		wr(8'h04, 32'h3);
		chk("power", 32'h3, 32'({pump, regu, fol}));
		rchk("unmapped", 8'h3C, 32'h0);
		wr(8'h00, 32'h1);
		chk("oe", 32'hD, 32'({pol_oe, syn_oe, tck_oe, blk_oe}));
		chk("osc", 32'h0, 32'(osc));
		chk("blank", 32'h1, 32'(blk));
		rchk("contrast", 8'h08, 32'h15);
		rchk("ratio", 8'h0C, 32'h5);
		span(n);
		span(n);
		chk("frame", 32'd65, 32'(n));
		chk("sync", 32'd33, 32'(hi));
		wr(8'h10, 32'h4);
		wr(8'h00, 32'h21);
		span(n);
		span(n);
		chk("line", 32'd5, 32'(n));
		wr(8'h00, 32'h1);
		for (int k = 0; k < 20 && n == 5; k++)
			span(n);
		span(n);
		chk("frame", 32'd65, 32'(n));
		wr(8'h00, 32'h2D08);
		scan_chk(1'b1, 45);
		wr(8'h00, 32'h0);
		scan_chk(1'b0, 0);
		conclude();
	end
endmodule
`default_nettype wire
